//--- verilog/apc_pkg.sv
// constants, field positions and types of the autoneg/config register bank
// assumes a 10 mhz system clock and management frames sampled on that clock
package apc_pkg;

  // register addresses on the management interface
  localparam logic [4:0]  APC_ADDR_ADVERTISE = 5'h04;
  localparam logic [4:0]  APC_ADDR_PARTNER   = 5'h05;
  localparam logic [4:0]  APC_ADDR_EXPANSION = 5'h06;
  localparam logic [4:0]  APC_ADDR_CONFIG    = 5'h10;

  // advertisement field positions and reset values
  localparam int          ADV_NEXT_PAGE_BIT  = 15;
  localparam int          ADV_ACK_BIT        = 14;
  localparam int          ADV_RF_BIT         = 13;
  localparam int          ADV_FCS_BIT        = 10;
  localparam int          ADV_T4_BIT         = 9;
  localparam int          ADV_ABIL_HI        = 8;
  localparam int          ADV_ABIL_LO        = 5;
  localparam int          ADV_SEL_HI         = 4;
  localparam int          ADV_SEL_LO         = 0;
  localparam logic        ADV_RF_RST         = 1'b0;
  localparam logic        ADV_FCS_RST        = 1'b0;
  localparam logic [3:0]  ADV_ABIL_RST       = 4'hf;
  localparam logic [4:0]  ADV_SEL_RST        = 5'h01;

  // partner ability: bits 12:11 are reserved and read zero
  localparam logic [15:0] LP_KEEP_MASK       = 16'he7ff;
  localparam logic [15:0] LP_RST             = 16'h0000;
  localparam int          LP_NEXT_PAGE_BIT   = 15;
  localparam int          LP_RF_BIT          = 13;

  // expansion field positions
  localparam int          EXP_PDF_BIT        = 4;
  localparam int          EXP_LP_NP_BIT      = 3;
  localparam int          EXP_LOCAL_NP_BIT   = 2;
  localparam int          EXP_PAGE_RX_BIT    = 1;
  localparam int          EXP_LP_AN_BIT      = 0;

  // vendor configuration field positions
  localparam int          CFG_BP_CODING_BIT  = 15;
  localparam int          CFG_BP_SCRAMBLE_BIT = 14;
  localparam int          CFG_BYPASS_SYMBOL_ALIGN_BIT   = 13;
  localparam int          CFG_BP_ADPOK_BIT   = 12;
  localparam int          CFG_REPEATER_BIT   = 11;
  localparam int          CFG_TX_MODE_BIT    = 10;
  localparam int          CFG_RMII_BIT       = 8;
  localparam int          CFG_FORCE_LINK_BIT = 7;
  localparam int          CFG_SPEED_LED_BIT  = 6;
  localparam int          CFG_COL_LED_BIT    = 5;
  localparam int          CFG_LOW_POWER_BIT  = 4;
  localparam int          CFG_SM_RESET_BIT   = 3;
  localparam int          CFG_PREAMBLE_BIT   = 2;
  localparam int          CFG_SLEEP_BIT      = 1;
  localparam int          CFG_LOOP_OUT_BIT   = 0;
  localparam logic [15:0] CFG_RST            = 16'h0414;
  localparam logic [15:0] CFG_WR_MASK        = 16'hfdff;
  localparam logic [15:0] CFG_FIXED_ONES     = 16'h0200;

  // management frame layout
  localparam logic [5:0]  MDIO_PREAMBLE_LEN  = 6'd32;
  localparam logic [5:0]  MDIO_HDR_LAST      = 6'd12;
  localparam logic [5:0]  MDIO_DATA_LAST     = 6'd15;
  localparam logic [1:0]  MDIO_OP_READ       = 2'b10;
  localparam logic [1:0]  MDIO_OP_WRITE      = 2'b01;

  // state machine reset pulse length
  localparam int          CLK_PERIOD_NS      = 100;
  localparam int          SM_RESET_TIME_NS   = 2000;
  localparam logic [7:0]  SM_RESET_CYCLES    = 8'((SM_RESET_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  // management frame states
  typedef enum logic [3:0] {
    MDIO_PRE  = 4'b0001,
    MDIO_HDR  = 4'b0010,
    MDIO_TA   = 4'b0100,
    MDIO_DATA = 4'b1000
  } apc_mdio_state_t;

endpackage : apc_pkg

//--- verilog/apc_mdio_slave.sv
// serial management frame engine: decodes read and write frames
// assumes mdc and mdio are synchronous to clk_sys_i and far slower than it
`timescale 1ns/1ps
module apc_mdio_slave
  import apc_pkg::*;
(
  input  wire logic        clk_sys_i,          // system clock
  input  wire logic        sys_rst_i,          // synchronous reset
  input  wire logic        mdc_i,              // management clock
  input  wire logic        mdio_i,             // management data in
  output logic             mdio_o,             // management data out
  output logic             mdio_oe_o,          // drive enable
  input  wire logic [4:0]  phy_addr_i,         // own address
  input  wire logic        preamble_skip_i,    // accept frames without preamble
  output logic             rd_req_o,           // read strobe
  output logic             wr_req_o,           // write strobe
  output logic [4:0]       reg_addr_o,         // register address
  output logic [15:0]      wr_data_o,          // write data
  input  wire logic [15:0] rd_data_i           // read data, valid after strobe
);

  typedef struct packed {
    apc_mdio_state_t st;
    logic            mdc;
    logic [5:0]      cnt;
    logic [15:0]     sh;
    logic            rd;
    logic            hit;
    logic            oe;
    logic            out;
    logic [4:0]      addr;
    logic            rd_req;
    logic            wr_req;
  } apc_mdio_regs_t;

  apc_mdio_regs_t q;
  apc_mdio_regs_t d;
  logic           rise;
  logic [12:0]    hdr;

  // rising mdc edge and the header as it completes
  assign rise = mdc_i & ~q.mdc;
  assign hdr  = {q.sh[11:0], mdio_i};

  // frame sequencing, one step per rising mdc edge
  always_comb begin
    d        = q;
    d.mdc    = mdc_i;
    d.rd_req = 1'b0;
    d.wr_req = 1'b0;
    if (rise) begin
      unique case (q.st)
        MDIO_PRE: begin
          if (mdio_i) begin
            if (q.cnt != MDIO_PREAMBLE_LEN) d.cnt = q.cnt + 6'd1;
          end else if (q.cnt == MDIO_PREAMBLE_LEN || preamble_skip_i) begin
            d.st  = MDIO_HDR;
            d.cnt = '0;
          end else begin
            d.cnt = '0;
          end
        end
        MDIO_HDR: begin
          d.sh  = {q.sh[14:0], mdio_i};
          d.cnt = q.cnt + 6'd1;
          if (q.cnt == MDIO_HDR_LAST) begin
            d.cnt  = '0;
            d.addr = hdr[4:0];
            d.rd   = hdr[11:10] == MDIO_OP_READ;
            d.hit  = hdr[9:5] == phy_addr_i;
            if (hdr[12] && (hdr[11:10] == MDIO_OP_READ || hdr[11:10] == MDIO_OP_WRITE)) begin
              d.st     = MDIO_TA;
              d.rd_req = (hdr[11:10] == MDIO_OP_READ) && (hdr[9:5] == phy_addr_i);
            end else begin
              d.st = MDIO_PRE;
            end
          end
        end
        MDIO_TA: begin
          d.cnt = q.cnt + 6'd1;
          if (q.cnt == '0) begin
            d.oe  = q.rd & q.hit;
            d.out = 1'b0;
          end else begin
            d.st  = MDIO_DATA;
            d.cnt = '0;
            d.sh  = rd_data_i;
            d.out = rd_data_i[15];
          end
        end
        MDIO_DATA: begin
          d.cnt = q.cnt + 6'd1;
          if (q.rd) begin
            d.sh  = {q.sh[14:0], 1'b0};
            d.out = q.sh[14];
          end else begin
            d.sh = {q.sh[14:0], mdio_i};
          end
          if (q.cnt == MDIO_DATA_LAST) begin
            d.st     = MDIO_PRE;
            d.cnt    = '0;
            d.oe     = 1'b0;
            d.wr_req = ~q.rd & q.hit;
          end
        end
      endcase
    end
  end

  // state register
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      q     <= '0;
      q.st  <= MDIO_PRE;
      q.mdc <= 1'b1;
    end else begin
      q <= d;
    end
  end

  assign mdio_o     = q.out;
  assign mdio_oe_o  = q.oe;
  assign rd_req_o   = q.rd_req;
  assign wr_req_o   = q.wr_req;
  assign reg_addr_o = q.addr;
  assign wr_data_o  = q.sh;

endmodule : apc_mdio_slave

//--- verilog/apc_autoneg_phy_regs.sv
// autoneg advertisement, partner, expansion and vendor config registers
// assumes the autoneg state machine, leds and datapath live outside
//
// What this block does
// - next page and four-pair bits read zero
// - local acknowledge comes only from autoneg
// - remote fault advert bit writable, resets zero
// - flow control advert bit writable, resets zero
// - four ability advert bits writable, reset one
// - selector field writable, resets to 00001
// - partner word read-only, captured from autoneg
// - partner acknowledge set by autoneg only
// - parallel detect fault latches until cleared
// - page received latches, clears on expansion read
// - partner autoneg/next-page bits; upper bits zero
// - local next page able reads zero
// - bit 15 bypasses block coding
// - bit 14 bypasses scrambling
// - bit 13 bypasses align, coding and scrambling
// - repeater and reduced mii from straps
// - forced link reports good 100m link
// - speed led disable, duplex/collision led select
// - auto low power enable resets to one
// - state machine reset self clears when done
// - sleep powers down, wake resets state machines
// - remote loop out returns rx to tx
// - basic status remote fault follows partner fault
`timescale 1ns/1ps
module apc_autoneg_phy_regs
  import apc_pkg::*;
(
  input  wire logic        clk_sys_i,              // 10 mhz system clock
  input  wire logic        sys_rst_i,              // synchronous reset, high
  // management interface
  input  wire logic        mdc_i,                  // management clock
  input  wire logic        mdio_i,                 // management data in
  output logic             mdio_o,                 // management data out
  output logic             mdio_oe_o,              // management drive enable
  input  wire logic [4:0]  phy_addr_i,             // own phy address
  // straps sampled during reset
  input  wire logic        strap_repeater_i,       // repeater mode strap
  input  wire logic        strap_rmii_i,           // reduced mii strap
  // autoneg state machine side
  input  wire logic        local_ack_i,            // acknowledge for outgoing bursts
  input  wire logic        lp_word_valid_i,        // partner code word strobe
  input  wire logic [15:0] lp_word_i,              // partner code word
  input  wire logic        lp_autoneg_able_i,      // partner does autoneg
  input  wire logic        parallel_detect_fault_i, // parallel detect fault pulse
  input  wire logic        page_received_i,        // new page pulse
  output logic [15:0]      advertise_word_o,       // local code word
  output logic             status_remote_fault_o,  // to basic status
  // datapath and line status
  input  wire logic        line_link_ok_i,         // link seen on line
  input  wire logic        speed_100_i,            // running at 100m
  input  wire logic        full_duplex_i,          // duplex state
  input  wire logic        collision_i,            // collision seen
  output logic             link_ok_o,              // reported link status
  output logic             bypass_block_coding_o,  // skip 4b5b coding
  output logic             bypass_scrambling_o,    // skip scrambler
  output logic             bypass_symbol_align_o,  // skip symbol alignment
  output logic             bypass_adpok_o,         // vendor adpok bypass
  output logic             tx_mode_o,              // 100base-tx mode
  output logic             repeater_mode_o,        // repeater not node
  output logic             rmii_enable_o,          // reduced mii
  output logic             speed_led_o,            // speed led drive
  output logic             duplex_led_o,           // duplex/collision led drive
  output logic             auto_low_power_enable_o, // auto power reduction allowed
  output logic             state_machine_reset_o,  // resets phy state machines
  output logic             sleep_o,                // power down all but clocks
  output logic             remote_loop_out_o       // loop rx data to tx
);

  typedef struct packed {
    logic        adv_rf;
    logic        adv_fcs;
    logic [3:0]  adv_abil;
    logic [4:0]  adv_sel;
    logic [15:0] lp;
    logic        parallel_detect_fault;
    logic        page_rx;
    logic [15:0] cfg;
    logic [7:0]  sm_cnt;
    logic        rf_status;
    logic [15:0] rd_data;
  } apc_bank_regs_t;

  apc_bank_regs_t q;
  apc_bank_regs_t d;
  apc_bank_regs_t rst_val;

  logic        rd_req;
  logic        wr_req;
  logic [4:0]  reg_addr;
  logic [15:0] wr_data;
  logic [15:0] adv_word;
  logic [15:0] exp_word;
  logic [15:0] cfg_word;
  logic [15:0] rd_mux;
  logic        wr_cfg;

  // serial management frame engine
  apc_mdio_slave u_mdio (
    .clk_sys_i       (clk_sys_i),
    .sys_rst_i       (sys_rst_i),
    .mdc_i           (mdc_i),
    .mdio_i          (mdio_i),
    .mdio_o          (mdio_o),
    .mdio_oe_o       (mdio_oe_o),
    .phy_addr_i      (phy_addr_i),
    .preamble_skip_i (q.cfg[CFG_PREAMBLE_BIT]),
    .rd_req_o        (rd_req),
    .wr_req_o        (wr_req),
    .reg_addr_o      (reg_addr),
    .wr_data_o       (wr_data),
    .rd_data_i       (q.rd_data)
  );

  // read views of the registers
  always_comb begin
    adv_word                          = '0;
    adv_word[ADV_NEXT_PAGE_BIT]       = 1'b0;
    adv_word[ADV_ACK_BIT]             = local_ack_i;
    adv_word[ADV_RF_BIT]              = q.adv_rf;
    adv_word[ADV_FCS_BIT]             = q.adv_fcs;
    adv_word[ADV_T4_BIT]              = 1'b0;
    adv_word[ADV_ABIL_HI:ADV_ABIL_LO] = q.adv_abil;
    adv_word[ADV_SEL_HI:ADV_SEL_LO]   = q.adv_sel;
  end

  // expansion view; bits 15:5 stay zero
  always_comb begin
    exp_word                   = '0;
    exp_word[EXP_PDF_BIT]      = q.parallel_detect_fault;
    exp_word[EXP_LP_NP_BIT]    = q.lp[LP_NEXT_PAGE_BIT];
    exp_word[EXP_LOCAL_NP_BIT] = 1'b0;
    exp_word[EXP_PAGE_RX_BIT]  = q.page_rx;
    exp_word[EXP_LP_AN_BIT]    = lp_autoneg_able_i;
  end

  assign cfg_word = q.cfg | CFG_FIXED_ONES;
  assign wr_cfg   = wr_req && reg_addr == APC_ADDR_CONFIG;

  // read data selection; other addresses answer zero
  always_comb begin
    unique case (reg_addr)
      APC_ADDR_ADVERTISE: rd_mux = adv_word;
      APC_ADDR_PARTNER:   rd_mux = q.lp;
      APC_ADDR_EXPANSION: rd_mux = exp_word;
      APC_ADDR_CONFIG:    rd_mux = cfg_word;
      default:            rd_mux = '0;
    endcase
  end

  // reset image, straps taken while reset is held
  always_comb begin
    rst_val                        = '0;
    rst_val.adv_rf                 = ADV_RF_RST;
    rst_val.adv_fcs                = ADV_FCS_RST;
    rst_val.adv_abil               = ADV_ABIL_RST;
    rst_val.adv_sel                = ADV_SEL_RST;
    rst_val.lp                     = LP_RST;
    rst_val.cfg                    = CFG_RST;
    rst_val.cfg[CFG_REPEATER_BIT]  = strap_repeater_i;
    rst_val.cfg[CFG_RMII_BIT]      = strap_rmii_i;
  end

  // register updates
  always_comb begin
    d = q;
    // advertisement writes; ack, next page and t4 are not stored
    if (wr_req && reg_addr == APC_ADDR_ADVERTISE) begin
      d.adv_rf   = wr_data[ADV_RF_BIT];
      d.adv_fcs  = wr_data[ADV_FCS_BIT];
      d.adv_abil = wr_data[ADV_ABIL_HI:ADV_ABIL_LO];
      d.adv_sel  = wr_data[ADV_SEL_HI:ADV_SEL_LO];
    end
    // partner word, only from autoneg, never from writes
    if (lp_word_valid_i) begin
      d.lp = lp_word_i & LP_KEEP_MASK;
    end
    // latching flags: the read clears, a new event wins
    if (rd_req && reg_addr == APC_ADDR_EXPANSION) begin
      d.parallel_detect_fault     = 1'b0;
      d.page_rx = 1'b0;
    end
    if (parallel_detect_fault_i) d.parallel_detect_fault = 1'b1;
    if (page_received_i) d.page_rx = 1'b1;
    // remote fault reaches basic status a cycle after the partner bit
    d.rf_status = q.lp[LP_RF_BIT];
    // read data captured from the pre-clear values
    if (rd_req) d.rd_data = rd_mux;
    // state machine reset countdown, clears its own bit at the end
    if (q.sm_cnt != '0) begin
      d.sm_cnt = q.sm_cnt - 8'd1;
      if (q.sm_cnt == 8'd1) d.cfg[CFG_SM_RESET_BIT] = 1'b0;
    end
    // configuration writes
    if (wr_cfg) begin
      d.cfg = (wr_data & CFG_WR_MASK) | (q.cfg & ~CFG_WR_MASK);
      // a zero written mid-countdown must not cancel it, nor pin the bit on at its last cycle
      if (q.sm_cnt > 8'd1) d.cfg[CFG_SM_RESET_BIT] = q.cfg[CFG_SM_RESET_BIT] | wr_data[CFG_SM_RESET_BIT];
      if (wr_data[CFG_SM_RESET_BIT]) d.sm_cnt = SM_RESET_CYCLES;
      // leaving sleep keeps settings but restarts the state machines
      if (q.cfg[CFG_SLEEP_BIT] && !wr_data[CFG_SLEEP_BIT]) begin
        d.sm_cnt = SM_RESET_CYCLES;
      end
    end
  end

  // state register
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      q <= rst_val;
    end else begin
      q <= d;
    end
  end

  // outputs toward autoneg and basic status
  assign advertise_word_o      = adv_word;
  assign status_remote_fault_o = q.rf_status;

  // datapath controls; alignment bypass also skips coding and scrambling
  assign bypass_block_coding_o = q.cfg[CFG_BP_CODING_BIT] | q.cfg[CFG_BYPASS_SYMBOL_ALIGN_BIT];
  assign bypass_scrambling_o   = q.cfg[CFG_BP_SCRAMBLE_BIT] | q.cfg[CFG_BYPASS_SYMBOL_ALIGN_BIT];
  assign bypass_symbol_align_o = q.cfg[CFG_BYPASS_SYMBOL_ALIGN_BIT];
  assign bypass_adpok_o        = q.cfg[CFG_BP_ADPOK_BIT];
  assign tx_mode_o             = q.cfg[CFG_TX_MODE_BIT];
  assign repeater_mode_o       = q.cfg[CFG_REPEATER_BIT];
  assign rmii_enable_o         = q.cfg[CFG_RMII_BIT];

  // forced link only counts at 100m
  assign link_ok_o = line_link_ok_i | (q.cfg[CFG_FORCE_LINK_BIT] & speed_100_i);

  // led behaviour
  assign speed_led_o  = speed_100_i & ~q.cfg[CFG_SPEED_LED_BIT];
  assign duplex_led_o = full_duplex_i | (q.cfg[CFG_COL_LED_BIT] & collision_i);

  // power and test controls
  assign auto_low_power_enable_o = q.cfg[CFG_LOW_POWER_BIT];
  assign sleep_o                 = q.cfg[CFG_SLEEP_BIT];
  assign state_machine_reset_o   = (q.sm_cnt != '0) | q.cfg[CFG_SLEEP_BIT];
  assign remote_loop_out_o       = q.cfg[CFG_LOOP_OUT_BIT];

endmodule : apc_autoneg_phy_regs

//--- dv/apc_assertions.sv
// checker for the autoneg/config register bank, watching top ports only
// bound onto apc_autoneg_phy_regs from the bench top file
`timescale 1ns/1ps
module apc_assertions (
  input wire logic        clk_sys_i,             // clock
  input wire logic        sys_rst_i,             // reset
  input wire logic        local_ack_i,           // autoneg ack
  input wire logic        lp_word_valid_i,       // partner strobe
  input wire logic [15:0] lp_word_i,             // partner word
  input wire logic [15:0] advertise_word_o,      // local word
  input wire logic        status_remote_fault_o, // fault to status
  input wire logic        line_link_ok_i,        // line link
  input wire logic        speed_100_i,           // speed
  input wire logic        full_duplex_i,         // duplex
  input wire logic        link_ok_o,             // reported link
  input wire logic        bypass_block_coding_o, // coding bypass
  input wire logic        bypass_scrambling_o,   // scrambler bypass
  input wire logic        bypass_symbol_align_o, // align bypass
  input wire logic        speed_led_o,           // speed led
  input wire logic        duplex_led_o,          // duplex led
  input wire logic        state_machine_reset_o, // sm reset
  input wire logic        sleep_o                // sleep
);
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (sys_rst_i);

  // fixed bits and the ack path of the local word
  property p_adv_fixed; !advertise_word_o[15] && !advertise_word_o[9]; endproperty
  a_adv_fixed: assert property (p_adv_fixed) else $error("fixed advert bit set");
  property p_adv_ack; advertise_word_o[14] == local_ack_i; endproperty
  a_adv_ack: assert property (p_adv_ack) else $error("advert ack not from autoneg");
  // partner fault reaches status two cycles after the partner strobe
  property p_rf; lp_word_valid_i && lp_word_i[13] |-> ##2 status_remote_fault_o; endproperty
  a_rf: assert property (p_rf) else $error("status fault missing");
  property p_align; bypass_symbol_align_o |-> bypass_block_coding_o && bypass_scrambling_o; endproperty
  a_align: assert property (p_align) else $error("align bypass incomplete");
  property p_link; !speed_100_i |-> link_ok_o == line_link_ok_i; endproperty
  a_link: assert property (p_link) else $error("forced link outside 100m");
  property p_led; (speed_led_o -> speed_100_i) && (full_duplex_i -> duplex_led_o); endproperty
  a_led: assert property (p_led) else $error("led drive wrong");
  // wake from sleep holds the state machines in reset
  property p_wake; $fell(sleep_o) |-> state_machine_reset_o [*8]; endproperty
  a_wake: assert property (p_wake) else $error("no reset on wake");
  property p_smr_done; $rose(state_machine_reset_o) && !sleep_o |-> ##[1:25] !state_machine_reset_o; endproperty
  a_smr_done: assert property (p_smr_done) else $error("sm reset never clears");
endmodule : apc_assertions

//--- dv/apc_sme_model.sv
// station management model sending preambled clause-22 frames
// the bench resolves the shared data line with a pull-up
`timescale 1ns/1ps
module apc_sme_model #(
  parameter logic [4:0] PHY_ADDR = 5'h01
) (
  input  wire logic clk_sys_i, // system clock
  input  wire logic mdio_i,    // resolved line
  output logic      mdc_o,     // management clock
  output logic      mdio_o,    // data when driving
  output logic      mdio_oe_o  // drive enable
);
  initial begin
    mdc_o = 1'b1;
    mdio_o = 1'b1;
    mdio_oe_o = 1'b0;
  end
  // one frame, four clocks per mdc half, data sampled before each rise
  task automatic xfer(input logic wr, input logic [4:0] ra, input logic [15:0] wd, output logic [15:0] rd);
    logic [63:0] f;
    f = {32'hffffffff, 2'b01, (wr ? 2'b01 : 2'b10), PHY_ADDR, ra, 2'b10, wd};
    rd = 16'h0000;
    for (int n = 63; n >= 0; n--) begin
      @(posedge clk_sys_i);
      #1;
      mdc_o = 1'b0;
      mdio_oe_o = wr || (n > 17); // released for turnaround and read data
      mdio_o = f[n];
      repeat (4) @(posedge clk_sys_i);
      #1;
      if (n < 16) rd[n] = mdio_i;
      mdc_o = 1'b1;
      repeat (3) @(posedge clk_sys_i);
    end
    @(posedge clk_sys_i);
    #1;
    mdio_oe_o = 1'b0;
  endtask : xfer
endmodule : apc_sme_model

//--- dv/apc_autoneg_phy_regs_bench.sv
// self-checking bench for apc_autoneg_phy_regs
// drives inputs 1 ns after the clock edge; frames come from the sme model
`timescale 1ns/1ps
module apc_autoneg_phy_regs_bench;
  logic clk_sys_i, sys_rst_i, mdc, line, dut_o, dut_oe, sme_o, sme_oe;
  logic strap_rep, strap_rmii, local_ack, lp_valid, lp_an, parallel_detect_fault, page, rep, rmii, txm, adpok;
  logic link_in, spd100, fdx, col, rf, link_ok, bc, bs, ba, spled, dled, alp, smr, slp, lo;
  logic [15:0] lp_word, adv;
  logic [4:0]  phy_a;
  int   fail_count, checks, cyc;
  // rows: write flag, address, data or expected read value
  logic [21:0] rows [12] = '{
    {1'b0, 5'h04, 16'h01e1}, {1'b0, 5'h05, 16'h0000}, {1'b0, 5'h06, 16'h0000},
    {1'b0, 5'h10, 16'h0f14}, {1'b1, 5'h04, 16'hffff}, {1'b0, 5'h04, 16'h25ff},
    {1'b1, 5'h05, 16'hffff}, {1'b0, 5'h05, 16'h0000}, {1'b0, 5'h07, 16'h0000},
    {1'b1, 5'h10, 16'h0000}, {1'b0, 5'h10, 16'h0200}, {1'b1, 5'h04, 16'h0000}};
  // config value beside expected {bc,bs,ba,link,spled,dled,alp,lo}
  logic [23:0] cfgv [5] = '{{16'h2000, 8'he8}, {16'h8000, 8'h88}, {16'h4000, 8'h48},
    {16'h00e1, 8'h15}, {16'h0010, 8'h0a}};
  wire [7:0] cfg_out = {bc, bs, ba, link_ok, spled, dled, alp, lo};

  // pulled-up management data line
  assign line = dut_oe ? dut_o : (sme_oe ? sme_o : 1'b1);

  apc_sme_model #(.PHY_ADDR(5'h01)) sme (.clk_sys_i(clk_sys_i), .mdio_i(line), .mdc_o(mdc),
    .mdio_o(sme_o), .mdio_oe_o(sme_oe));

  apc_autoneg_phy_regs DUT (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .mdc_i(mdc), .mdio_i(line),
    .mdio_o(dut_o), .mdio_oe_o(dut_oe), .phy_addr_i(phy_a), .strap_repeater_i(strap_rep),
    .strap_rmii_i(strap_rmii), .local_ack_i(local_ack), .lp_word_valid_i(lp_valid), .lp_word_i(lp_word),
    .lp_autoneg_able_i(lp_an), .parallel_detect_fault_i(parallel_detect_fault), .page_received_i(page),
    .advertise_word_o(adv), .status_remote_fault_o(rf), .line_link_ok_i(link_in), .speed_100_i(spd100),
    .full_duplex_i(fdx), .collision_i(col), .link_ok_o(link_ok), .bypass_block_coding_o(bc),
    .bypass_scrambling_o(bs), .bypass_symbol_align_o(ba), .bypass_adpok_o(adpok), .tx_mode_o(txm),
    .repeater_mode_o(rep), .rmii_enable_o(rmii), .speed_led_o(spled), .duplex_led_o(dled),
    .auto_low_power_enable_o(alp), .state_machine_reset_o(smr), .sleep_o(slp), .remote_loop_out_o(lo));

  // 10 mhz clock
  initial begin
    clk_sys_i = 1'b0;
    forever #50 clk_sys_i = ~clk_sys_i;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys_i);
    #1;
  endtask : tick

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    logic [15:0] r;
    sme.xfer(1'b1, a, d, r);
  endtask : wr

  task automatic rdc(input logic [4:0] a, input logic [15:0] e);
    logic [15:0] r;
    sme.xfer(1'b0, a, 16'h0000, r);
    chk(r, e);
  endtask : rdc

  task automatic end_sim();
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : end_sim

  // hang guard
  always @(posedge clk_sys_i) begin
    cyc++;
    if (cyc == 30000) begin
      fail_count++;
      end_sim();
    end
  end

  initial begin
    {local_ack, lp_valid, lp_an, parallel_detect_fault, page, link_in, spd100, fdx, col} = '0;
    lp_word = 16'h0000;
    phy_a = 5'h01;
    {strap_rep, strap_rmii} = 2'b11;
    sys_rst_i = 1'b1;
    tick(20);
    sys_rst_i = 1'b0;
    tick(2);
    chk({15'h0000, alp}, 16'h0001);
    chk({12'h000, adpok, txm, rep, rmii}, 16'h0007);
    foreach (rows[i]) begin
      if (rows[i][21]) wr(rows[i][20:16], rows[i][15:0]);
      else rdc(rows[i][20:16], rows[i][15:0]);
    end
    $display("register table test done");
    spd100 = 1'b1;
    col = 1'b1;
    foreach (cfgv[i]) begin
      wr(5'h10, cfgv[i][23:8]);
      chk({8'h00, cfg_out}, {8'h00, cfgv[i][7:0]});
    end
    $display("config output test done");
    wr(5'h10, 16'h0008);
    chk({15'h0000, smr}, 16'h0001);
    rdc(5'h10, 16'h0200);
    wr(5'h10, 16'h0002);
    chk({14'h0000, slp, smr}, 16'h0003);
    wr(5'h10, 16'h0000);
    chk({14'h0000, slp, smr}, 16'h0001);
    $display("reset and sleep test done");
    local_ack = 1'b1;
    lp_word = 16'hffff;
    lp_valid = 1'b1;
    tick(1);
    lp_valid = 1'b0;
    tick(3);
    chk({rf, adv[14], 14'h0000}, 16'hc000);
    rdc(5'h05, 16'he7ff);
    rdc(5'h04, 16'h4000);
    lp_an = 1'b1;
    {parallel_detect_fault, page} = 2'b11;
    tick(1);
    {parallel_detect_fault, page} = 2'b00;
    rdc(5'h06, 16'h001b);
    rdc(5'h06, 16'h0009);
    $display("partner and expansion test done");
    // frames for another address are neither answered nor written
    phy_a = 5'h02;
    wr(5'h04, 16'h01e0);
    rdc(5'h04, 16'hffff);
    phy_a = 5'h01;
    rdc(5'h04, 16'h4000);
    $display("address filter test done");
    sys_rst_i = 1'b1;
    {strap_rep, strap_rmii} = 2'b00;
    tick(2);
    sys_rst_i = 1'b0;
    tick(2);
    rdc(5'h10, 16'h0614);
    rdc(5'h05, 16'h0000);
    chk({12'h000, adpok, txm, rep, rmii}, 16'h0004);
    $display("second reset test done");
    end_sim();
  end
endmodule : apc_autoneg_phy_regs_bench

bind apc_autoneg_phy_regs apc_assertions u_chk (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i),
  .local_ack_i(local_ack_i), .lp_word_valid_i(lp_word_valid_i), .lp_word_i(lp_word_i),
  .advertise_word_o(advertise_word_o), .status_remote_fault_o(status_remote_fault_o),
  .line_link_ok_i(line_link_ok_i), .speed_100_i(speed_100_i), .full_duplex_i(full_duplex_i),
  .link_ok_o(link_ok_o), .bypass_block_coding_o(bypass_block_coding_o),
  .bypass_scrambling_o(bypass_scrambling_o), .bypass_symbol_align_o(bypass_symbol_align_o),
  .speed_led_o(speed_led_o), .duplex_led_o(duplex_led_o),
  .state_machine_reset_o(state_machine_reset_o), .sleep_o(sleep_o));
